/* File: design/sac_pkg.sv */
// constants and types shared by the converter control block
package sac_pkg;
    // ****************************************************************
    // register map on the processor access port
    // ****************************************************************
    localparam logic [15:0] SAC_MODE_ADDR = 16'hFF80; // conversion_mode
    localparam logic [15:0] SAC_CHAN_ADDR = 16'hFF84; // input_channel_select
    localparam logic [15:0] SAC_RESULT_ADDR = 16'hFF88; // conversion_result
    localparam logic [7:0] SAC_MODE_RESET = 8'h00;
    localparam logic [7:0] SAC_CHAN_RESET = 8'h00;
    localparam logic [7:0] SAC_UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SAC_ENABLE_BIT = 7; // convert_enable
    localparam int SAC_TCODE_LSB = 3; // conv_time_code_b0
    localparam int SAC_TCODE_MSB = 5; // conv_time_code_b2
    localparam int SAC_CHAN_MSB = 2; // channel_index_b2
    localparam int SAC_RES_BITS = 8; // result width
    localparam int SAC_CHANNELS = 8; // analog_inputs

    // ****************************************************************
    // conversion timing, in system clocks
    // ****************************************************************
    localparam int SAC_CONV_CLK_0 = 288; // code 000
    localparam int SAC_CONV_CLK_1 = 240; // code 001
    localparam int SAC_CONV_CLK_2 = 192; // code 010
    localparam int SAC_CONV_CLK_4 = 144; // code 100
    localparam int SAC_CONV_CLK_5 = 120; // code 101
    localparam int SAC_SAMPLE_STEPS = 4; // opening steps spent sampling
    localparam int SAC_STEPS = SAC_SAMPLE_STEPS + SAC_RES_BITS; // steps per conversion
    localparam logic [3:0] SAC_LAST_SAMPLE = 4'(SAC_SAMPLE_STEPS - 1);
    localparam logic [3:0] SAC_LAST_STEP = 4'(SAC_STEPS - 1);
    localparam logic [7:0] SAC_MSB_TRIAL = 8'h80; // half-scale tap

    // sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_CONVERT = 2'b10
    } sac_state_t;

    // clocks per step for a time code; prohibited codes fall back to the slowest
    function automatic logic [4:0] sac_unit_len(input logic [2:0] code);
        logic [4:0] len;
        len = 5'(SAC_CONV_CLK_0 / SAC_STEPS);
        unique case (code)
            3'h1: len = 5'(SAC_CONV_CLK_1 / SAC_STEPS);
            3'h2: len = 5'(SAC_CONV_CLK_2 / SAC_STEPS);
            3'h4: len = 5'(SAC_CONV_CLK_4 / SAC_STEPS);
            3'h5: len = 5'(SAC_CONV_CLK_5 / SAC_STEPS);
            default: len = 5'(SAC_CONV_CLK_0 / SAC_STEPS);
        endcase
        return len;
    endfunction : sac_unit_len
endpackage : sac_pkg

/* File: design/sac_step_timer.sv */
// step timer: divides a conversion into equal steps of unit_len clocks
module sac_step_timer
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic run,
    input wire logic [4:0] unit_len,
    output logic [3:0] step_idx,
    output logic step_end
);
    // ****************************************************************
    // counters
    // ****************************************************************
    logic [4:0] unit_cnt_r; // clocks into the current step
    logic [3:0] step_r; // current step number
    logic last_step; // final step of a conversion

    // a step ends on its last clock while running
    assign step_end = run && !restart && (unit_cnt_r == unit_len - 5'h01);
    assign last_step = (step_r == SAC_LAST_STEP);
    assign step_idx = step_r;

    // count clocks, then steps; wrap for back to back conversions
    always_ff @(posedge clk)
    begin
        if (reset || restart || !run)
        begin
            unit_cnt_r <= 5'h00;
            step_r <= 4'h0;
        end
        else if (step_end)
        begin
            unit_cnt_r <= 5'h00;
            step_r <= last_step ? 4'h0 : step_r + 4'h1;
        end
        else
        begin
            unit_cnt_r <= unit_cnt_r + 5'h01;
        end
    end
endmodule : sac_step_timer

/* File: design/sac_approx.sv */
// approximation shift register: one trial bit per decide, msb first
module sac_approx
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic decide,
    input wire logic comp_ge,
    output logic [7:0] approx,
    output logic [7:0] tap_code
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] approx_r; // decided bits
    logic [7:0] mask_r; // one-hot trial bit
    logic [7:0] tap_r; // ladder tap in use
    logic [7:0] approx_nxt; // bits after this decision
    logic [7:0] mask_nxt; // next trial bit

    // keep the trial bit only when input reaches the tap
    assign approx_nxt = comp_ge ? (approx_r | mask_r) : approx_r;
    assign mask_nxt = mask_r >> 1;
    assign approx = approx_r;
    assign tap_code = tap_r;

    // clear starts at half scale; each decide moves one bit lower
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            approx_r <= 8'h00;
            mask_r <= 8'h00;
            tap_r <= 8'h00;
        end
        else if (clear)
        begin
            approx_r <= 8'h00;
            mask_r <= SAC_MSB_TRIAL;
            tap_r <= SAC_MSB_TRIAL;
        end
        else if (decide && mask_r != 8'h00)
        begin
            approx_r <= approx_nxt;
            mask_r <= mask_nxt;
            tap_r <= approx_nxt | mask_nxt;
        end
    end
endmodule : sac_approx

/* File: design/sac_top.sv */
// control and sequencing for the 8-bit successive approximation converter
// Contract
// - 8-bit result from one of eight inputs
// - only a software enable write starts conversion
// - convert back to back, interrupt each time
// - resolve msb first, then copy to result
// - result 8 bits, readable, unreset, loaded each conversion
// - sample selected input, then hold for comparisons
// - mode bit 7 enables; reset clears mode
// - time code picks 288/240/192/144/120 clocks
// - channel bits pick input; reset clears register
// - first result after enable may be junk
// - result after disable may be junk
// - first trial bit 7 at half scale
// - lower bits tried against tap from decided bits
// - after bit 0, latch result and interrupt
// - mode or channel write aborts; restarts if enabled, else stops
// - register write beats result update, no interrupt
// - read served before coinciding result update
module sac_top
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic comp_ge,
    output logic [7:0] tap_code,
    output logic [2:0] channel_sel,
    output logic sample_hold,
    output logic conversion_done_irq
);
    // ****************************************************************
    // register access decode
    // ****************************************************************
    logic mode_wr; // write to conversion_mode
    logic chan_wr; // write to input_channel_select
    logic ctrl_wr; // either control write
    logic [7:0] rd_mux; // read data selection

    assign mode_wr = cpu_wr && (cpu_addr == SAC_MODE_ADDR);
    assign chan_wr = cpu_wr && (cpu_addr == SAC_CHAN_ADDR);
    assign ctrl_wr = mode_wr || chan_wr;

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic convert_enable_r; // mode bit 7
    logic [2:0] time_code_r; // mode bits 5..3
    logic [2:0] chan_r; // channel index
    logic [7:0] result_r; // conversion result, no reset
    logic [7:0] rdata_r; // registered read data
    logic enable_nxt; // enable after this cycle's write
    logic [7:0] mode_view; // mode as software reads it

    assign mode_view = {convert_enable_r, 1'b0, time_code_r, 3'h0};
    assign enable_nxt = mode_wr ? cpu_wdata[SAC_ENABLE_BIT] : convert_enable_r;

    // mode register: enable plus time code, cleared by reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            convert_enable_r <= SAC_MODE_RESET[SAC_ENABLE_BIT];
            time_code_r <= SAC_MODE_RESET[SAC_TCODE_MSB:SAC_TCODE_LSB];
        end
        else if (mode_wr)
        begin
            convert_enable_r <= cpu_wdata[SAC_ENABLE_BIT];
            time_code_r <= cpu_wdata[SAC_TCODE_MSB:SAC_TCODE_LSB];
        end
    end

    // channel register: upper bits are not stored and read as zero
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            chan_r <= SAC_CHAN_RESET[SAC_CHAN_MSB:0];
        end
        else if (chan_wr)
        begin
            chan_r <= cpu_wdata[SAC_CHAN_MSB:0];
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    sac_state_t state_r; // sequencer state
    sac_state_t state_nxt; // next state
    logic [4:0] unit_len; // clocks per step
    logic [3:0] step_idx; // step within conversion
    logic step_end; // last clock of a step
    logic timer_run; // timer counts while converting
    logic last_sample; // end of the sampling steps
    logic last_compare; // end of the bit 0 step
    logic sar_clear; // start comparisons at half scale
    logic sar_decide; // latch one comparison
    logic [7:0] approx; // approximation shift register
    logic done_pend_r; // all bits decided last cycle
    logic load_result; // result update allowed this cycle

    assign unit_len = sac_unit_len(time_code_r);
    assign timer_run = (state_r != SAC_IDLE);
    assign last_sample = (state_r == SAC_SAMPLE) && step_end && (step_idx == SAC_LAST_SAMPLE);
    assign last_compare = (state_r == SAC_CONVERT) && step_end && (step_idx == SAC_LAST_STEP);
    assign sar_clear = last_sample && !ctrl_wr;
    assign sar_decide = (state_r == SAC_CONVERT) && step_end && !ctrl_wr;

    // next state: a control write restarts or stops, else walk the steps
    always_comb
    begin
        state_nxt = state_r;
        if (ctrl_wr)
        begin
            state_nxt = enable_nxt ? SAC_SAMPLE : SAC_IDLE;
        end
        else
        begin
            unique case (state_r)
                SAC_IDLE: state_nxt = SAC_IDLE;
                SAC_SAMPLE: state_nxt = last_sample ? SAC_CONVERT : SAC_SAMPLE;
                SAC_CONVERT: state_nxt = last_compare ? SAC_SAMPLE : SAC_CONVERT;
                default: state_nxt = SAC_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= SAC_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // step timer restarts on every control write
    sac_step_timer u_timer (
        .clk(clk),
        .reset(reset),
        .restart(ctrl_wr),
        .run(timer_run),
        .unit_len(unit_len),
        .step_idx(step_idx),
        .step_end(step_end)
    );

    // bit engine driving the ladder tap
    sac_approx u_approx (
        .clk(clk),
        .reset(reset),
        .clear(sar_clear),
        .decide(sar_decide),
        .comp_ge(comp_ge),
        .approx(approx),
        .tap_code(tap_code)
    );

    // ****************************************************************
    // result and completion
    // ****************************************************************
    // a control write in the load cycle drops the result and interrupt
    assign load_result = done_pend_r && !ctrl_wr;

    // remember that bit 0 was decided
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_pend_r <= 1'b0;
        end
        else
        begin
            done_pend_r <= last_compare && !ctrl_wr;
        end
    end

    // result register keeps no reset value; first result after enable
    // and the one after disable are not guaranteed meaningful
    always_ff @(posedge clk)
    begin
        if (load_result)
        begin
            result_r <= approx;
        end
    end

    // read mux: unmapped addresses read zero
    assign rd_mux = (cpu_addr == SAC_MODE_ADDR) ? mode_view :
                    (cpu_addr == SAC_CHAN_ADDR) ? {5'h00, chan_r} :
                    (cpu_addr == SAC_RESULT_ADDR) ? result_r : SAC_UNMAPPED_READ;

    // read data captures the old result when a load coincides
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_r <= SAC_UNMAPPED_READ;
        end
        else if (cpu_rd)
        begin
            rdata_r <= rd_mux;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cpu_rdata = rdata_r;
    assign conversion_done_irq = load_result;
    assign sample_hold = (state_r == SAC_SAMPLE);
    assign channel_sel = chan_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [8:0] period_cnt_r; // clocks since the last interrupt
    logic period_ok_r; // no control write since last interrupt

    // helper: measure spacing of undisturbed interrupts
    always_ff @(posedge clk)
    begin
        if (reset || conversion_done_irq)
        begin
            period_cnt_r <= 9'h001;
            period_ok_r <= !reset && !ctrl_wr;
        end
        else
        begin
            period_cnt_r <= period_cnt_r + 9'h001;
            period_ok_r <= period_ok_r && !ctrl_wr;
        end
    end

    sequence s_enter_hold;
        sample_hold ##1 (state_r == SAC_CONVERT);
    endsequence

    sequence s_enable_write;
        mode_wr && cpu_wdata[SAC_ENABLE_BIT];
    endsequence

    a_irq_load_value: assert property (
        conversion_done_irq |=> result_r == $past(approx))
        else $error("result not loaded from approximation");
    a_first_tap_half: assert property (
        s_enter_hold |-> tap_code == SAC_MSB_TRIAL)
        else $error("first comparison tap is not half scale");
    a_restart_sample: assert property (
        s_enable_write |=> sample_hold && step_idx == 4'h0)
        else $error("enable write did not restart sampling");
    a_idle_stays_idle: assert property (
        (state_r == SAC_IDLE && !ctrl_wr) |=> state_r == SAC_IDLE)
        else $error("conversion started without a write");
    a_hold_while_compare: assert property (
        (state_r == SAC_CONVERT && !ctrl_wr && !last_compare) |=> !sample_hold)
        else $error("sampling reopened during comparisons");
    a_write_drops_irq: assert property (
        (done_pend_r && ctrl_wr) |-> !conversion_done_irq ##1 $stable(result_r))
        else $error("result updated despite control write");
    a_read_old_value: assert property (
        (cpu_rd && cpu_addr == SAC_RESULT_ADDR && load_result)
        |=> cpu_rdata == $past(result_r))
        else $error("read did not return the previous result");
    a_conv_period: assert property (
        (conversion_done_irq && period_ok_r && !ctrl_wr)
        |-> period_cnt_r == 9'(SAC_STEPS) * 9'(unit_len))
        else $error("conversion length does not match time code");
    a_reset_clears: assert property (
        $past(reset) |-> mode_view == SAC_MODE_RESET && chan_r == 3'h0)
        else $error("control registers not cleared by reset");
    a_tap_from_bits: assert property (
        (sar_decide && step_idx == SAC_LAST_SAMPLE + 4'h1 && comp_ge)
        |=> tap_code == 8'hC0)
        else $error("bit 6 tap not three quarters after bit 7 kept");

    sequence s_disable_write;
        mode_wr && !cpu_wdata[SAC_ENABLE_BIT];
    endsequence

    a_disable_stops: assert property (
        s_disable_write |=> !sample_hold && !conversion_done_irq)
        else $error("disable write did not stop conversion");
    a_irq_single: assert property (
        conversion_done_irq |=> !conversion_done_irq)
        else $error("completion interrupt longer than one cycle");
    a_chan_select: assert property (
        chan_wr |=> channel_sel == $past(cpu_wdata[SAC_CHAN_MSB:0]))
        else $error("channel select does not follow the write");
endmodule : sac_top

/* File: testbench/sac_analog_model.sv */
// behavioural comparator, ladder tap and input multiplexer
module sac_analog_model
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [63:0] levels, // eight input levels, channel 0 in the low byte
    input wire logic [2:0] channel_sel,
    input wire logic sample_hold,
    input wire logic [7:0] tap_code,
    output logic comp_ge
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] held_r; // level kept on the sample capacitor
    // track the selected input while sampling, freeze it while holding
    // the shared pins are only seen through the sampler, never read as port data
    always_ff @(posedge clk)
    begin
        if (reset)
            held_r <= 8'h00;
        else if (sample_hold)
            held_r <= levels[{channel_sel, 3'h0} +: 8];
    end
    // comparator: high once the held level reaches the tap
    assign comp_ge = (held_r >= tap_code);
endmodule : sac_analog_model

/* File: testbench/sar_adc_control_tb_top.sv */
// self-checking bench for the converter control block
module sar_adc_control_tb_top
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // signals and bench model state
    // ****************************************************************
    logic clk, reset, cpu_wr, cpu_rd, comp_ge, sample_hold, conversion_done_irq;
    logic [15:0] cpu_addr; // register address
    logic [7:0] cpu_wdata, cpu_rdata, tap_code, v, seed, old, nl, nl2;
    logic [2:0] channel_sel, ch; // mux index out, and the one chosen here
    logic [63:0] levels; // analog levels fed to the far side
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5}; // legal time codes
    int clks [5] = '{SAC_CONV_CLK_0, SAC_CONV_CLK_1, SAC_CONV_CLK_2, SAC_CONV_CLK_4,
        SAC_CONV_CLK_5};
    int lvl [8]; // model copy of each input level
    int exp_q[$]; // expected results of the bench model, oldest first
    int mismatches, tests_run, cyc, irq_hit, t_mark, n, ic, ic2, u;
    sac_top uut (.clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .comp_ge(comp_ge),
        .tap_code(tap_code), .channel_sel(channel_sel), .sample_hold(sample_hold),
        .conversion_done_irq(conversion_done_irq));
    sac_analog_model far_side (.clk(clk), .reset(reset), .levels(levels),
        .channel_sel(channel_sel), .sample_hold(sample_hold), .tap_code(tap_code),
        .comp_ge(comp_ge));
    // 40 MHz clock and a cycle counter
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ****************************************************************
    // helpers: random source, compares, bus cycles
    // ****************************************************************
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    // bench model: resolve an integer level msb first against each trial tap
    function automatic int model_sar(input int level);
        int acc;
        acc = 0;
        for (int b = 7; b >= 0; b--)
        begin
            if (level >= (acc | (1 << b)))
                acc = acc | (1 << b);
        end
        return acc;
    endfunction : model_sar
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_cnt
    // one-cycle write; notes whether the interrupt showed in that cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        cpu_wr = 1'b1;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk);
        irq_hit = int'(conversion_done_irq === 1'b1);
        @(posedge clk);
        #2;
        t_mark = cyc;
        cpu_wr = 1'b0;
    endtask : wr
    // one-cycle read; data is taken once it has settled
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #2;
        cpu_rd = 1'b1;
        cpu_addr = a;
        @(negedge clk);
        irq_hit = int'(conversion_done_irq === 1'b1);
        @(posedge clk);
        #2;
        cpu_rd = 1'b0;
        d = cpu_rdata;
    endtask : rd
    // bounded wait for the next interrupt pulse, returns its cycle
    task automatic wait_irq(output int c);
        int k;
        k = 0;
        @(negedge clk);
        while (conversion_done_irq !== 1'b1 && k < 1000)
        begin
            k++;
            @(negedge clk);
        end
        if (k >= 1000)
            mismatches++;
        c = cyc;
    endtask : wait_irq
    task automatic at_cyc(input int c);
        while (cyc < c)
        begin
            @(posedge clk);
            #1;
        end
    endtask : at_cyc
    task automatic quiet(input int span, output int cnt);
        cnt = 0;
        repeat (span)
        begin
            @(negedge clk);
            if (conversion_done_irq === 1'b1)
                cnt++;
        end
        @(posedge clk);
        #2;
    endtask : quiet
    task automatic close_out();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    // watchdog: far beyond the longest expected run
    initial
    begin
        repeat (30000) @(posedge clk);
        mismatches++;
        close_out();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        reset = 1'b1;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        levels = 64'h0;
        seed = 8'h5E;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        #2;
        reset = 1'b0;
        // reset values, an unmapped read, plain register writes
        rd(SAC_MODE_ADDR, v);
        chk_val(v, SAC_MODE_RESET);
        rd(SAC_CHAN_ADDR, v);
        chk_val(v, SAC_CHAN_RESET);
        rd(16'hFF90, v);
        chk_val(v, SAC_UNMAPPED_READ);
        wr(SAC_CHAN_ADDR, 8'h05);
        rd(SAC_CHAN_ADDR, v);
        chk_val(v, 8'h05);
        wr(SAC_MODE_ADDR, 8'h28);
        rd(SAC_MODE_ADDR, v);
        chk_val(v, 8'h28);
        quiet(300, n);
        chk_cnt(n, 0);
        // every legal time code: timing, sampling span, result value
        for (int i = 0; i < 5; i++)
        begin
            u = clks[i] / SAC_STEPS;
            for (int j = 0; j < 8; j++)
            begin
                seed = lfsr_next(seed);
                levels[j*8 +: 8] = seed;
                lvl[j] = int'(seed);
            end
            ch = seed[2:0];
            wr(SAC_CHAN_ADDR, {5'h00, ch});
            chk_val({5'h00, channel_sel}, {5'h00, ch});
            wr(SAC_MODE_ADDR, {2'b10, codes[i], 3'b000});
            n = 0;
            @(negedge clk);
            while (sample_hold === 1'b1 && n < 400)
            begin
                n++;
                @(negedge clk);
            end
            chk_cnt(n, 4 * u);
            wait_irq(ic);
            chk_cnt(ic - t_mark, 12 * u);
            wait_irq(ic2);
            chk_cnt(ic2 - ic, 12 * u);
            rd(SAC_RESULT_ADDR, v);
            chk_val(v, 8'(model_sar(lvl[ch])));
        end
        // read in the load cycle, then a write in the load cycle
        old = 8'(model_sar(lvl[ch]));
        seed = lfsr_next(seed);
        nl = old ^ (seed | 8'h01);
        levels[{ch, 3'h0} +: 8] = nl;
        exp_q.push_back(model_sar(int'(nl)));
        at_cyc(ic2 + 12 * u - 1);
        rd(SAC_RESULT_ADDR, v);
        chk_cnt(irq_hit, 1);
        chk_val(v, old);
        rd(SAC_RESULT_ADDR, v);
        chk_val(v, 8'(exp_q[0]));
        seed = lfsr_next(seed);
        nl2 = nl ^ (seed | 8'h01);
        levels[{ch, 3'h0} +: 8] = nl2;
        exp_q.push_back(model_sar(int'(nl2)));
        at_cyc(ic2 + 24 * u - 1);
        wr(SAC_CHAN_ADDR, {5'h00, ch});
        chk_cnt(irq_hit, 0);
        rd(SAC_RESULT_ADDR, v);
        chk_val(v, 8'(exp_q.pop_front()));
        wait_irq(ic);
        chk_cnt(ic - t_mark, 12 * u);
        rd(SAC_RESULT_ADDR, v);
        chk_val(v, 8'(exp_q.pop_front()));
        // clearing the enable bit stops conversion
        wr(SAC_MODE_ADDR, 8'h00);
        quiet(400, n);
        chk_cnt(n, 0);
        rd(SAC_MODE_ADDR, v);
        chk_val(v, 8'h00);
        close_out();
    end
endmodule : sar_adc_control_tb_top
